/* shared/phy_mgmt_map.vh */
`ifndef PHY_MGMT_MAP_VH
`define PHY_MGMT_MAP_VH

// register addresses on the management interface
`define ADDR_GIG_STATUS      5'h0a
`define ADDR_EXT_STATUS      5'h0f
`define ADDR_CTRL_SECOND     5'h12
`define ADDR_RX_ERR_COUNT    5'h14

// gigabit link status fields
`define GS_MS_FAULT          15
`define GS_MS_MASTER         14
`define GS_LOC_RX_OK         13
`define GS_REM_RX_OK         12
`define GS_LP_1000_FULL      11
`define GS_LP_1000_HALF      10
`define GS_IDLE_MSB          7
`define GS_IDLE_LSB          0
`define IDLE_COUNT_MAX       8'hff

// extended capability status is a constant word
`define EXT_STATUS_VALUE     16'h3000

// second control word fields
`define CS_RESOLVE_BEFORE    15
`define CS_COUNT_FALSE_CARR  14
`define CS_COUNT_SYMBOL      13
`define CS_AUTO_CROSSOVER    10
`define CS_MANUAL_MDIX       9
`define CS_DIAG_ENABLE       2
`define CTRL_SECOND_RESET    16'h8400
`define CTRL_SECOND_WMASK    16'he604

// receive error counter
`define RX_ERR_MAX           16'hffff

// management frame timing, in link clock bits
`define MDIO_PREAMBLE_BITS   6'd32
`define MDIO_HEADER_BITS     6'd13
`define MDIO_DATA_BITS       6'd16
`define MDIO_OP_READ         2'b10
`define MDIO_OP_WRITE        2'b01

`endif

/* hw/mgmt_serial_port.v */
`timescale 1ns/1ps
`include "phy_mgmt_map.vh"

module mgmt_serial_port
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // management pins
  input  wire        mdc_i,
  input  wire        mdio_i,
  output reg         mdio_o,
  output reg         mdio_oe_n_o,
  // own address
  input  wire [4:0]  phy_addr_i,
  // register side
  output reg  [4:0]  reg_addr_o,
  output reg         rd_stb_o,
  input  wire [15:0] rd_data_i,
  output reg         wr_stb_o,
  output reg  [15:0] wr_data_o
);

  localparam [1:0] ST_PRE = 2'd0;
  localparam [1:0] ST_HDR = 2'd1;
  localparam [1:0] ST_RD  = 2'd2;
  localparam [1:0] ST_WR  = 2'd3;

  reg        mdc_s1_reg;
  reg        mdc_s2_reg;
  reg        mdc_q_reg;
  reg        mdio_s1_reg;
  reg        mdio_s2_reg;
  reg [1:0]  state_reg;
  reg [5:0]  cnt_reg;
  reg [15:0] sh_reg;
  wire       mdc_rise;
  wire [15:0] sh_in;

  // only the second stage feeds the edge detector
  assign mdc_rise = mdc_s2_reg & ~mdc_q_reg;
  assign sh_in    = {sh_reg[14:0], mdio_s2_reg};

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mdc_s1_reg  <= 1'b0;
      mdc_s2_reg  <= 1'b0;
      mdc_q_reg   <= 1'b0;
      mdio_s1_reg <= 1'b1;
      mdio_s2_reg <= 1'b1;
    end
    else
    begin
      mdc_s1_reg  <= mdc_i;
      mdc_s2_reg  <= mdc_s1_reg;
      mdc_q_reg   <= mdc_s2_reg;
      mdio_s1_reg <= mdio_i;
      mdio_s2_reg <= mdio_s1_reg;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg   <= ST_PRE;
      cnt_reg     <= 6'd0;
      sh_reg      <= 16'h0000;
      reg_addr_o  <= 5'h00;
      rd_stb_o    <= 1'b0;
      wr_stb_o    <= 1'b0;
      wr_data_o   <= 16'h0000;
      mdio_o      <= 1'b1;
      mdio_oe_n_o <= 1'b1;
    end
    else
    begin
      rd_stb_o <= 1'b0;
      wr_stb_o <= 1'b0;
      // read word is taken the cycle the strobe is seen, long before the first data edge
      if (rd_stb_o)
        sh_reg <= rd_data_i;
      if (mdc_rise)
      begin
        case (state_reg)
          ST_PRE:
          begin
            if (mdio_s2_reg)
            begin
              if (cnt_reg < `MDIO_PREAMBLE_BITS)
                cnt_reg <= cnt_reg + 6'd1;
            end
            else if (cnt_reg == `MDIO_PREAMBLE_BITS)
            begin
              state_reg <= ST_HDR;
              cnt_reg   <= 6'd0;
            end
            else
              cnt_reg <= 6'd0;
          end
          ST_HDR:
          begin
            sh_reg  <= sh_in;
            cnt_reg <= cnt_reg + 6'd1;
            if (cnt_reg == `MDIO_HEADER_BITS - 6'd1)
            begin
              cnt_reg    <= 6'd0;
              reg_addr_o <= sh_in[4:0];
              state_reg  <= ST_PRE;
              // start bit, own address, then the opcode picks the direction
              if (sh_in[12] && sh_in[9:5] == phy_addr_i)
              begin
                if (sh_in[11:10] == `MDIO_OP_READ)
                begin
                  state_reg <= ST_RD;
                  rd_stb_o  <= 1'b1;
                end
                else if (sh_in[11:10] == `MDIO_OP_WRITE)
                  state_reg <= ST_WR;
              end
            end
          end
          ST_RD:
          begin
            cnt_reg <= cnt_reg + 6'd1;
            if (cnt_reg == 6'd0)
            begin
              mdio_o      <= 1'b0;
              mdio_oe_n_o <= 1'b0;
            end
            else if (cnt_reg <= `MDIO_DATA_BITS)
            begin
              mdio_o <= sh_reg[15];
              sh_reg <= {sh_reg[14:0], 1'b0};
            end
            else
            begin
              mdio_o      <= 1'b1;
              mdio_oe_n_o <= 1'b1;
              cnt_reg     <= 6'd0;
              state_reg   <= ST_PRE;
            end
          end
          ST_WR:
          begin
            cnt_reg <= cnt_reg + 6'd1;
            if (cnt_reg >= 6'd2)
              sh_reg <= sh_in;
            if (cnt_reg == `MDIO_DATA_BITS + 6'd1)
            begin
              wr_data_o <= sh_in;
              wr_stb_o  <= 1'b1;
              cnt_reg   <= 6'd0;
              state_reg <= ST_PRE;
            end
          end
          default:
          begin
            state_reg <= ST_PRE;
            cnt_reg   <= 6'd0;
          end
        endcase
      end
    end
  end

endmodule // mgmt_serial_port

/* hw/gbe_phy_status_ctrl_regs.v */
`timescale 1ns/1ps
`include "phy_mgmt_map.vh"

// Function
// - ms fault flag latches; cleared by status read, reset, autoneg done or enabled
// - bit 14 shows master (1) or slave (0) resolution; invalid while fault set
// - bit 13 local receiver ok, bit 12 remote receiver ok
// - bits 11 and 10 show partner gigabit full and half duplex ability
// - idle error count increments on idle errors while both receivers are ok
// - idle count saturates at 255, cleared by status read or reset
// - extended status reads constant: only gigabit full and half duplex bits set
// - control bit 15 resolves crossover before forced speed; reset value 1
// - control bits 14 and 13 pick receive error types; both reset to 0
// - bit 14 adds false carrier events to receive error count
// - bit 13 counts symbol errors, else CRC errors
// - selection table combines symbol or CRC errors with optional false carriers
// - receive error counter is 16-bit read-only and clears after a read
// - control bit 10 enables automatic crossover; reset value 1
// - control bit 9 picks manual MDI-X (1) or MDI (0)
// - manual crossover setting acts only while automatic crossover is off
// - control bit 2 enables powered-phone detection and reflectometry tests
module gbe_phy_status_ctrl_regs
(
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // management pins and own address straps
  input  wire       mdc_i,
  input  wire       mdio_i,
  output wire       mdio_o,
  output wire       mdio_oe_n_o,
  input  wire [4:0] phy_addr_i,
  // link training state
  input  wire       ms_fault_det_i,
  input  wire       ms_master_i,
  input  wire       an_complete_i,
  input  wire       an_enable_i,
  input  wire       loc_rx_ok_i,
  input  wire       rem_rx_ok_i,
  input  wire       lp_gig_full_i,
  input  wire       lp_gig_half_i,
  // error events, one cycle each
  input  wire       idle_err_i,
  input  wire       crc_err_i,
  input  wire       symbol_err_i,
  input  wire       false_carrier_i,
  // controls towards the datapath
  output reg        resolve_before_force_o,
  output reg        auto_crossover_o,
  output reg        manual_mdix_o,
  output reg        diag_enable_o
);

  reg         ms_fault_reg;
  reg         ms_master_reg;
  reg         loc_rx_ok_reg;
  reg         rem_rx_ok_reg;
  reg         lp_full_reg;
  reg         lp_half_reg;
  reg  [7:0]  idle_cnt_reg;
  reg  [7:0]  idle_cnt_next;
  reg  [15:0] ctrl_reg;
  reg  [15:0] rx_err_reg;
  reg  [15:0] rx_err_next;
  reg  [15:0] rd_data;
  reg         rx_err_event;
  wire [4:0]  reg_addr;
  wire        rd_stb;
  wire        wr_stb;
  wire [15:0] wr_data;
  wire        rd_gig_status;
  wire        rd_rx_err;
  wire        idle_count_ok;
  reg  [4:0]  phy_addr_s1_reg;
  reg  [4:0]  phy_addr_s2_reg;

  // reset image of the control word; the outputs start from the same bits
  localparam [15:0] CTRL_RESET = `CTRL_SECOND_RESET;

  mgmt_serial_port u_port
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .mdc_i       (mdc_i),
    .mdio_i      (mdio_i),
    .mdio_o      (mdio_o),
    .mdio_oe_n_o (mdio_oe_n_o),
    .phy_addr_i  (phy_addr_s2_reg),
    .reg_addr_o  (reg_addr),
    .rd_stb_o    (rd_stb),
    .rd_data_i   (rd_data),
    .wr_stb_o    (wr_stb),
    .wr_data_o   (wr_data)
  );

  // address straps are board pins; two stages keep a strap change from
  // reaching the header compare half settled
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phy_addr_s1_reg <= 5'h00;
      phy_addr_s2_reg <= 5'h00;
    end
    else
    begin
      phy_addr_s1_reg <= phy_addr_i;
      phy_addr_s2_reg <= phy_addr_s1_reg;
    end
  end

  assign rd_gig_status = rd_stb && (reg_addr == `ADDR_GIG_STATUS);
  assign rd_rx_err     = rd_stb && (reg_addr == `ADDR_RX_ERR_COUNT);
  assign idle_count_ok = loc_rx_ok_reg & rem_rx_ok_reg;

  // read mux; unmapped addresses and reserved bits read zero
  always @*
  begin
    rd_data = 16'h0000;
    case (reg_addr)
      `ADDR_GIG_STATUS:
      begin
        rd_data[`GS_MS_FAULT]     = ms_fault_reg;
        // resolution is forced low while the fault stands, since it means nothing then
        rd_data[`GS_MS_MASTER]    = ms_master_reg & ~ms_fault_reg;
        rd_data[`GS_LOC_RX_OK]    = loc_rx_ok_reg;
        rd_data[`GS_REM_RX_OK]    = rem_rx_ok_reg;
        rd_data[`GS_LP_1000_FULL] = lp_full_reg;
        rd_data[`GS_LP_1000_HALF] = lp_half_reg;
        rd_data[`GS_IDLE_MSB:`GS_IDLE_LSB] = idle_cnt_reg;
      end
      `ADDR_EXT_STATUS:
        rd_data = `EXT_STATUS_VALUE;
      `ADDR_CTRL_SECOND:
        rd_data = ctrl_reg & `CTRL_SECOND_WMASK;
      `ADDR_RX_ERR_COUNT:
        rd_data = rx_err_reg;
      default:
        rd_data = 16'h0000;
    endcase
  end

  // idle errors: the read clears, but an error landing in the same cycle survives
  always @*
  begin
    idle_cnt_next = rd_gig_status ? 8'h00 : idle_cnt_reg;
    if (idle_err_i && idle_count_ok && idle_cnt_next != `IDLE_COUNT_MAX)
      idle_cnt_next = idle_cnt_next + 8'h01;
  end

  // receive error type selection
  always @*
  begin
    rx_err_event = ctrl_reg[`CS_COUNT_SYMBOL] ? symbol_err_i : crc_err_i;
    if (ctrl_reg[`CS_COUNT_FALSE_CARR] && false_carrier_i)
      rx_err_event = 1'b1;
    rx_err_next = rd_rx_err ? 16'h0000 : rx_err_reg;
    // held at full scale instead of wrapping, so a long gap between reads shows as maximum
    if (rx_err_event && rx_err_next != `RX_ERR_MAX)
      rx_err_next = rx_err_next + 16'h0001;
  end

  // status sampling and latched fault
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ms_fault_reg  <= 1'b0;
      ms_master_reg <= 1'b0;
      loc_rx_ok_reg <= 1'b0;
      rem_rx_ok_reg <= 1'b0;
      lp_full_reg   <= 1'b0;
      lp_half_reg   <= 1'b0;
      idle_cnt_reg  <= 8'h00;
      rx_err_reg    <= 16'h0000;
    end
    else
    begin
      // a new fault in the clearing cycle wins over every clear source except reset
      if (ms_fault_det_i)
        ms_fault_reg <= 1'b1;
      else if (rd_gig_status || an_complete_i || an_enable_i)
        ms_fault_reg <= 1'b0;
      ms_master_reg <= ms_master_i;
      loc_rx_ok_reg <= loc_rx_ok_i;
      rem_rx_ok_reg <= rem_rx_ok_i;
      lp_full_reg   <= lp_gig_full_i;
      lp_half_reg   <= lp_gig_half_i;
      idle_cnt_reg  <= idle_cnt_next;
      rx_err_reg    <= rx_err_next;
    end
  end

  // second control word; only this word accepts writes
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_reg <= `CTRL_SECOND_RESET;
    else if (wr_stb && reg_addr == `ADDR_CTRL_SECOND)
      ctrl_reg <= wr_data & `CTRL_SECOND_WMASK;
  end

  // control outputs; diagnostics while linked is left to the station
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      resolve_before_force_o <= CTRL_RESET[`CS_RESOLVE_BEFORE];
      auto_crossover_o       <= CTRL_RESET[`CS_AUTO_CROSSOVER];
      manual_mdix_o          <= CTRL_RESET[`CS_MANUAL_MDIX] & ~CTRL_RESET[`CS_AUTO_CROSSOVER];
      diag_enable_o          <= CTRL_RESET[`CS_DIAG_ENABLE];
    end
    else
    begin
      resolve_before_force_o <= ctrl_reg[`CS_RESOLVE_BEFORE];
      auto_crossover_o       <= ctrl_reg[`CS_AUTO_CROSSOVER];
      manual_mdix_o          <= ctrl_reg[`CS_MANUAL_MDIX] &
                                ~ctrl_reg[`CS_AUTO_CROSSOVER];
      diag_enable_o          <= ctrl_reg[`CS_DIAG_ENABLE];
    end
  end

endmodule // gbe_phy_status_ctrl_regs

/* tb/gbe_phy_status_ctrl_regs_sva.sv */
`timescale 1ns/1ps
module gbe_phy_status_ctrl_regs_sva
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // management pins
  input wire mdio_o,
  input wire mdio_oe_n_o,
  // controls
  input wire resolve_before_force_o,
  input wire auto_crossover_o,
  input wire manual_mdix_o,
  input wire diag_enable_o
);
  default clocking cb @(posedge clk_i); endclocking

  // checked one edge later: the first clock edge is what applies the reset
  chk_reset_resolve: assert property (rst_i |=> resolve_before_force_o)
    else $error("resolve control low in reset");
  chk_reset_auto: assert property (rst_i |=> auto_crossover_o)
    else $error("auto crossover low in reset");
  chk_reset_mdix: assert property (rst_i |=> !manual_mdix_o)
    else $error("manual crossover high in reset");
  chk_reset_diag: assert property (rst_i |=> !diag_enable_o)
    else $error("diagnostics enabled in reset");
  chk_mdix_gated: assert property (disable iff (rst_i) !(manual_mdix_o && auto_crossover_o))
    else $error("manual crossover active with auto crossover");
  chk_reset_released: assert property (rst_i |=> mdio_oe_n_o)
    else $error("data pin driven in reset");
  chk_idle_high: assert property (disable iff (rst_i) mdio_oe_n_o |-> mdio_o)
    else $error("data output not high while released");
  // a turnaround zero opens a drive that is checked to hold for one link period, the next seven clocks
  chk_turn_hold: assert property (disable iff (rst_i)
    $fell(mdio_oe_n_o) |-> !mdio_o ##1 !mdio_oe_n_o [*7])
    else $error("read drive too short");
  chk_bit_stands: assert property (disable iff (rst_i)
    !mdio_oe_n_o && $changed(mdio_o) |=> $stable(mdio_o) [*6])
    else $error("read bit changed within a link period");
  chk_ctrl_quiet: assert property (disable iff (rst_i) !mdio_oe_n_o |->
    $stable({resolve_before_force_o, auto_crossover_o, manual_mdix_o, diag_enable_o}))
    else $error("controls changed during a read");

  cover property (disable iff (rst_i) $fell(mdio_oe_n_o));
  cover property (disable iff (rst_i) manual_mdix_o);
  cover property (disable iff (rst_i) diag_enable_o && !auto_crossover_o);
endmodule // gbe_phy_status_ctrl_regs_sva

bind gbe_phy_status_ctrl_regs gbe_phy_status_ctrl_regs_sva u_sva
(
  .clk_i                  (clk_i),
  .rst_i                  (rst_i),
  .mdio_o                 (mdio_o),
  .mdio_oe_n_o            (mdio_oe_n_o),
  .resolve_before_force_o (resolve_before_force_o),
  .auto_crossover_o       (auto_crossover_o),
  .manual_mdix_o          (manual_mdix_o),
  .diag_enable_o          (diag_enable_o)
);

/* tb/mdio_station.sv */
`timescale 1ns/1ps
module mdio_station
(
  // clock
  input  wire  clk_i,
  // management pins
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_n_o,
  input  wire  mdio_i
);
  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_n_o = 1'b1;
  end

  // the link clock runs only inside a frame, 8 system cycles a bit
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffff_ffff, 2'b01, op, pa, ra, 2'b10, wd};
    for (int i = 0; i < 64; i++)
    begin
      @(posedge clk_i);
      mdc_o <= 1'b0;
      mdio_o <= f[63 - i];
      mdio_oe_n_o <= (op == 2'b10) && (i > 45);
      repeat (4) @(posedge clk_i);
      if (i > 47)
        rd[63 - i] = mdio_i;
      mdc_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i);
    mdc_o <= 1'b0;
    mdio_oe_n_o <= 1'b1;
  endtask
endmodule // mdio_station

/* tb/gbe_phy_status_ctrl_regs_test.sv */
`timescale 1ns/1ps
module gbe_phy_status_ctrl_regs_test;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [6:0] ev = 7'h00;
  logic [4:0] lv = 5'h00;
  wire        mdc, st_d, st_oe_n, dv_d, dv_oe_n;
  wire  [3:0] ctl;
  // pulled-up shared data line
  wire        mdio = !dv_oe_n ? dv_d : (!st_oe_n ? st_d : 1'b1);
  int         n_fail = 0;
  int         comparisons = 0;

  always #20 clk_i = ~clk_i;

  mdio_station st
  (.clk_i(clk_i), .mdc_o(mdc), .mdio_o(st_d), .mdio_oe_n_o(st_oe_n), .mdio_i(mdio));

  gbe_phy_status_ctrl_regs DUT
  (
    .clk_i(clk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(mdio), .mdio_o(dv_d),
    .mdio_oe_n_o(dv_oe_n), .phy_addr_i(5'h05), .ms_fault_det_i(ev[4]),
    .ms_master_i(lv[4]), .an_complete_i(ev[5]), .an_enable_i(ev[6]),
    .loc_rx_ok_i(lv[3]), .rem_rx_ok_i(lv[2]), .lp_gig_full_i(lv[1]),
    .lp_gig_half_i(lv[0]), .idle_err_i(ev[0]), .crc_err_i(ev[1]),
    .symbol_err_i(ev[2]), .false_carrier_i(ev[3]),
    .resolve_before_force_o(ctl[3]), .auto_crossover_o(ctl[2]),
    .manual_mdix_o(ctl[1]), .diag_enable_o(ctl[0])
  );

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] op = 2'b01);
    logic [15:0] r;
    st.frame(op, 5'h05, a, d, r);
    repeat (4) @(posedge clk_i);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [4:0] pa = 5'h05);
    logic [15:0] r;
    st.frame(2'b10, pa, a, 16'h0000, r);
    check($sformatf("word %h", a), e, r);
  endtask

  task automatic pulse(input logic [6:0] m, input int n);
    repeat (n) @(posedge clk_i) ev <= m;
    @(posedge clk_i) ev <= 7'h00;
  endtask

  task automatic lev(input logic [4:0] v);
    @(posedge clk_i) lv <= v;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic finish_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    finish_test;
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check("controls", 16'h000c, {12'h000, ctl});
    rd(5'h12, 16'hffff, 5'h06);
    wr(5'h1f, 16'hffff);
    rd(5'h1f, 16'h0000);
    // an undefined opcode must leave the control word alone
    wr(5'h12, 16'h0000, 2'b11);
    rd(5'h12, 16'h8400);
    rd(5'h0f, 16'h3000);
    wr(5'h0f, 16'hffff);
    rd(5'h0f, 16'h3000);
    wr(5'h0a, 16'hffff);
    rd(5'h0a, 16'h0000);
    lev(5'h1e);
    pulse(7'h01, 3);
    rd(5'h0a, 16'h7803);
    rd(5'h0a, 16'h7800);
    lev(5'h19);
    pulse(7'h01, 2);
    rd(5'h0a, 16'h6400);
    lev(5'h1e);
    pulse(7'h01, 260);
    rd(5'h0a, 16'h78ff);
    pulse(7'h10, 1);
    rd(5'h0a, 16'hb800);
    rd(5'h0a, 16'h7800);
    for (int k = 5; k < 7; k++)
    begin
      pulse(7'h10, 1);
      pulse(7'h01 << k, 1);
      rd(5'h0a, 16'h7800);
    end
    // diagnostics are only switched on with the link down
    lev(5'h00);
    wr(5'h12, 16'hffff);
    check("controls", 16'h000d, {12'h000, ctl});
    rd(5'h12, 16'he604);
    wr(5'h12, 16'h0204);
    check("controls", 16'h0003, {12'h000, ctl});
    wr(5'h12, 16'h0000);
    check("controls", 16'h0000, {12'h000, ctl});
    for (int s = 0; s < 4; s++)
    begin
      wr(5'h12, {1'b0, s[1:0], 13'h0000});
      pulse(7'h02, 1);
      pulse(7'h04, 2);
      pulse(7'h08, 4);
      rd(5'h14, 16'((s[0] ? 2 : 1) + (s[1] ? 4 : 0)));
      rd(5'h14, 16'h0000);
    end
    finish_test;
  end
endmodule // gbe_phy_status_ctrl_regs_test
